/* rtl/vcs_params.svh */
`ifndef VCS_PARAMS_SVH
`define VCS_PARAMS_SVH

// architectural sizes
`define VCS_XLEN 32
`define VCS_NUM_VREGS 32
`define VCS_VREG_ADDR_BITS 5
`define VCS_VREG_BITS 128
`define VCS_MAX_ELEMENT_BITS 64

// context status encoding
`define VCS_CTX_OFF 2'h0
`define VCS_CTX_INITIAL 2'h1
`define VCS_CTX_CLEAN 2'h2
`define VCS_CTX_DIRTY 2'h3

// context status field position in the status views
`define VCS_VS_MSB 10
`define VCS_VS_LSB 9

// vector type field positions
`define VCS_VT_MASK_AGN 7
`define VCS_VT_TAIL_AGN 6
`define VCS_VT_SEW_MSB 5
`define VCS_VT_SEW_LSB 3
`define VCS_VT_GROUP_MULTIPLIER_MSB 2
`define VCS_VT_GROUP_MULTIPLIER_LSB 0
`define VCS_VT_RSVD_LSB 8

// encodings
`define VCS_GROUP_MULTIPLIER_RESERVED 3'h4
`define VCS_SEW_CODE_64 2'h3

// reset values
`define VCS_MISA_V_RESET 1'h1
`define VCS_ILL_RESET 1'h1

`endif

/* rtl/vcs_pkg.sv */
`include "vcs_params.svh"

package vcs_pkg;

  typedef enum logic [1:0] {
    ctx_off = `VCS_CTX_OFF,
    ctx_initial = `VCS_CTX_INITIAL,
    ctx_clean = `VCS_CTX_CLEAN,
    ctx_dirty = `VCS_CTX_DIRTY
  } vcs_ctx_t;

  typedef struct packed {
    logic config_illegal;
    logic mask_agnostic;
    logic tail_agnostic;
    logic [2:0] element_width_sel;
    logic [2:0] group_mult_sel;
  } vcs_vtype_t;

  // one decoded operation from the pipeline
  typedef struct packed {
    logic valid;
    logic is_csr;
    logic csr_write;
    logic csr_is_vtype;
    logic modifies;
  } vcs_op_t;

  typedef struct packed {
    vcs_ctx_t mstatus_vs;
    vcs_ctx_t sstatus_vs;
    vcs_ctx_t vsstatus_vs;
    logic mstatus_sd;
    logic vsstatus_sd;
  } vcs_status_t;

  // element width in bits for a width code, zero for reserved codes
  function automatic logic [7:0] vcs_sew_bits(input logic [2:0] code);
    logic [7:0] r;
    r = 8'h00;
    case (code)
      3'h0: r = 8'h08;
      3'h1: r = 8'h10;
      3'h2: r = 8'h20;
      3'h3: r = 8'h40;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : vcs_sew_bits

endpackage : vcs_pkg

/* rtl/vcs_vector_state.sv */
// Summary of operation
// - thirty-two vector registers of parameter width
// - context field at 10:9, supervisor view mirrors
// - machine field off traps vector work
// - state change turns initial/clean into dirty
// - may go dirty early without change
// - machine summary bit set when dirty
// - field exists without enable; enable writable
// - guest field at 10:9 with hypervisor
// - virtualized: either field off traps
// - virtualized change dirties both fields
// - guest summary bit set when dirty
// - type register read-only, set-length updates
// - top bit flags illegal configuration
// - type layout: agnostic bits, width, multiplier
// - width codes 8,16,32,64; top bit reserved
// - register holds bits/width elements
// - narrow build stores seven bits only
// - widths may depend on multiplier
// - multiplier is signed power of two
// - too-small fraction may flag illegal
`timescale 1ns/100ps
`default_nettype none
`include "vcs_params.svh"

module vcs_vector_state #(
  parameter int XLEN = `VCS_XLEN,
  parameter int VECTOR_REG_BITS = `VCS_VREG_BITS,
  parameter int MAX_ELEMENT_BITS = `VCS_MAX_ELEMENT_BITS,
  parameter bit HYP_PRESENT = 1'b1,
  parameter bit VS_RESET_ON = 1'b0,
  parameter bit EAGER_DIRTY = 1'b0,
  parameter bit RESTRICT_FRAC = 1'b1,
  parameter bit COMPACT_VTYPE = (MAX_ELEMENT_BITS == 32)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire vcs_pkg::vcs_op_t op,
  input wire logic virt_mode,
  input wire logic misa_v_wr,
  input wire logic misa_v_wdata,
  output logic misa_v,
  input wire logic ms_vs_wr,
  input wire logic [1:0] ms_vs_wdata,
  input wire logic gs_vs_wr,
  input wire logic [1:0] gs_vs_wdata,
  input wire logic ms_sd_base,
  input wire logic gs_sd_base,
  input wire logic setvl_valid,
  input wire logic [XLEN-1:0] setvl_vtype,
  input wire logic vreg_we,
  input wire logic [`VCS_VREG_ADDR_BITS-1:0] vreg_waddr,
  input wire logic [VECTOR_REG_BITS-1:0] vreg_wdata,
  input wire logic [`VCS_VREG_ADDR_BITS-1:0] vreg_raddr,
  output logic [VECTOR_REG_BITS-1:0] vreg_rdata,
  output vcs_pkg::vcs_status_t status,
  output logic illegal_instr,
  output logic [XLEN-1:0] vtype_rdata,
  output vcs_pkg::vcs_vtype_t vtype_fields,
  output logic [16:0] elements_per_reg
);
  import vcs_pkg::*;

  if (XLEN != 32 && XLEN != 64) begin : g_bad_xlen
    $error("XLEN must be 32 or 64");
  end
  if (MAX_ELEMENT_BITS != 32 && MAX_ELEMENT_BITS != 64) begin : g_bad_max_element_bits
    $error("widest element must be 32 or 64 bits");
  end
  if (VECTOR_REG_BITS < MAX_ELEMENT_BITS || VECTOR_REG_BITS > 65536
      || (VECTOR_REG_BITS & (VECTOR_REG_BITS - 1)) != 0) begin : g_bad_vector_reg_bits
    $error("vector register width must be a power of two, >= widest element");
  end
  if (COMPACT_VTYPE && MAX_ELEMENT_BITS != 32) begin : g_bad_compact
    $error("compact type storage needs a 32-bit widest element");
  end

  localparam vcs_ctx_t VS_RESET = VS_RESET_ON ? ctx_initial : ctx_off;

  // ---------------- context status ----------------
  vcs_ctx_t ms_vs;
  vcs_ctx_t gs_vs;
  logic misa_v_q;
  vcs_ctx_t next_ms_vs;
  vcs_ctx_t next_gs_vs;
  logic next_misa_v;

  logic guest_active;
  logic blocked;
  logic vtype_write_try;
  logic op_legal;
  logic setvl_legal;
  logic vreg_we_legal;
  logic state_change;

  always_comb begin
    guest_active = HYP_PRESENT && virt_mode;
    blocked = (ms_vs == ctx_off)
            | (guest_active & (gs_vs == ctx_off))
            | ~misa_v_q;
    vtype_write_try = op.valid & op.is_csr & op.csr_write & op.csr_is_vtype;
    illegal_instr = ((op.valid | setvl_valid) & blocked)
                  | vtype_write_try;
    op_legal = op.valid & ~illegal_instr;
    setvl_legal = setvl_valid & ~blocked;
    vreg_we_legal = vreg_we & ~blocked;
    state_change = (op_legal & (op.modifies | (op.is_csr & op.csr_write)))
                 | setvl_legal | vreg_we_legal;
    if (EAGER_DIRTY) begin
      state_change = state_change | op_legal | setvl_legal;
    end
  end

  always_comb begin
    next_misa_v = misa_v_wr ? misa_v_wdata : misa_v_q;
    // software write first, hardware dirtying wins over it unless the write is off
    next_ms_vs = ms_vs_wr ? vcs_ctx_t'(ms_vs_wdata) : ms_vs;
    if (state_change && next_ms_vs != ctx_off) begin
      next_ms_vs = ctx_dirty;
    end
    next_gs_vs = gs_vs;
    if (HYP_PRESENT) begin
      if (gs_vs_wr) begin
        next_gs_vs = vcs_ctx_t'(gs_vs_wdata);
      end
      if (guest_active && state_change && next_gs_vs != ctx_off) begin
        next_gs_vs = ctx_dirty;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_vs <= VS_RESET;
      gs_vs <= VS_RESET;
      misa_v_q <= `VCS_MISA_V_RESET;
    end else begin
      ms_vs <= next_ms_vs;
      gs_vs <= next_gs_vs;
      misa_v_q <= next_misa_v;
    end
  end

  always_comb begin
    misa_v = misa_v_q;
    status.mstatus_vs = ms_vs;
    status.sstatus_vs = ms_vs;
    status.vsstatus_vs = HYP_PRESENT ? gs_vs : ctx_off;
    status.mstatus_sd = ms_sd_base | (ms_vs == ctx_dirty);
    status.vsstatus_sd = HYP_PRESENT
                       & (gs_sd_base | (gs_vs == ctx_dirty));
  end

  // ---------------- vector type ----------------
  vcs_vtype_t vt_req;
  vcs_vtype_t vt_cur;

  vcs_vtype_check #(
    .XLEN(XLEN),
    .MAX_ELEMENT_BITS(MAX_ELEMENT_BITS),
    .RESTRICT_FRAC(RESTRICT_FRAC)
  ) u_check (
    .req_raw(setvl_vtype),
    .result(vt_req)
  );

  if (COMPACT_VTYPE) begin : g_compact
    // illegal kept as the unused 64-bit width code
    logic [6:0] vt_small;
    logic [6:0] next_vt_small;

    always_comb begin
      next_vt_small = vt_small;
      if (setvl_legal) begin
        if (vt_req.config_illegal) begin
          next_vt_small = {2'h0, `VCS_SEW_CODE_64, 3'h0};
        end else begin
          next_vt_small = {vt_req.mask_agnostic, vt_req.tail_agnostic,
                           vt_req.element_width_sel[1:0], vt_req.group_mult_sel};
        end
      end
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        vt_small <= {2'h0, `VCS_SEW_CODE_64, 3'h0};
      end else begin
        vt_small <= next_vt_small;
      end
    end

    always_comb begin
      vt_cur = '0;
      if (vt_small[4:3] == `VCS_SEW_CODE_64) begin
        vt_cur.config_illegal = 1'b1;
      end else begin
        vt_cur.mask_agnostic = vt_small[6];
        vt_cur.tail_agnostic = vt_small[5];
        vt_cur.element_width_sel = {1'b0, vt_small[4:3]};
        vt_cur.group_mult_sel = vt_small[2:0];
      end
    end
  end else begin : g_full
    vcs_vtype_t vt_q;
    vcs_vtype_t next_vt;

    always_comb begin
      next_vt = vt_q;
      if (setvl_legal) begin
        next_vt = vt_req;
      end
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        vt_q <= '{config_illegal: `VCS_ILL_RESET, default: '0};
      end else begin
        vt_q <= next_vt;
      end
    end

    always_comb begin
      vt_cur = vt_q;
    end
  end

  logic [3:0] sew_log2;

  always_comb begin
    vtype_fields = vt_cur;
    vtype_rdata = '0;
    vtype_rdata[XLEN-1] = vt_cur.config_illegal;
    vtype_rdata[`VCS_VT_MASK_AGN] = vt_cur.mask_agnostic;
    vtype_rdata[`VCS_VT_TAIL_AGN] = vt_cur.tail_agnostic;
    vtype_rdata[`VCS_VT_SEW_MSB:`VCS_VT_SEW_LSB] = vt_cur.element_width_sel;
    vtype_rdata[`VCS_VT_GROUP_MULTIPLIER_MSB:`VCS_VT_GROUP_MULTIPLIER_LSB] = vt_cur.group_mult_sel;
    // element size is 8 << code, so count is a plain shift
    sew_log2 = 4'(4'h3 + {2'h0, vt_cur.element_width_sel[1:0]});
    if (vt_cur.config_illegal || vcs_sew_bits(vt_cur.element_width_sel) == 8'h00) begin
      elements_per_reg = '0;
    end else begin
      elements_per_reg = 17'(VECTOR_REG_BITS >> sew_log2);
    end
  end

  // ---------------- register file ----------------
  vcs_vreg_file #(
    .NUM_REGS(`VCS_NUM_VREGS),
    .ADDR_BITS(`VCS_VREG_ADDR_BITS),
    .REG_BITS(VECTOR_REG_BITS)
  ) u_vregs (
    .clk(clk),
    .arst_n(arst_n),
    .we(vreg_we_legal),
    .waddr(vreg_waddr),
    .wdata(vreg_wdata),
    .raddr(vreg_raddr),
    .rdata(vreg_rdata)
  );

endmodule : vcs_vector_state
`default_nettype wire

/* rtl/vcs_vreg_file.sv */
`timescale 1ns/100ps
`default_nettype none
`include "vcs_params.svh"

module vcs_vreg_file #(
  parameter int NUM_REGS = `VCS_NUM_VREGS,
  parameter int ADDR_BITS = `VCS_VREG_ADDR_BITS,
  parameter int REG_BITS = `VCS_VREG_BITS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic we,
  input wire logic [ADDR_BITS-1:0] waddr,
  input wire logic [REG_BITS-1:0] wdata,
  input wire logic [ADDR_BITS-1:0] raddr,
  output logic [REG_BITS-1:0] rdata
);
  import vcs_pkg::*;

  logic [REG_BITS-1:0] regs [NUM_REGS];
  logic [REG_BITS-1:0] next_rdata;

  always_comb begin
    next_rdata = regs[raddr];
  end

  // storage has no reset, only the read port does
  always_ff @(posedge clk) begin
    if (we) begin
      regs[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule : vcs_vreg_file
`default_nettype wire

/* rtl/vcs_vtype_check.sv */
`timescale 1ns/100ps
`default_nettype none
`include "vcs_params.svh"

module vcs_vtype_check #(
  parameter int XLEN = `VCS_XLEN,
  parameter int MAX_ELEMENT_BITS = `VCS_MAX_ELEMENT_BITS,
  parameter bit RESTRICT_FRAC = 1'b1
) (
  input wire logic [XLEN-1:0] req_raw,
  output vcs_pkg::vcs_vtype_t result
);
  import vcs_pkg::*;

  logic [7:0] selected_element_width;
  logic [2:0] group_multiplier;
  logic [11:0] sew_scaled;
  logic [3:0] shift;
  logic bad;

  always_comb begin
    selected_element_width = vcs_sew_bits(req_raw[`VCS_VT_SEW_MSB:`VCS_VT_SEW_LSB]);
    group_multiplier = req_raw[`VCS_VT_GROUP_MULTIPLIER_MSB:`VCS_VT_GROUP_MULTIPLIER_LSB];
    shift = group_multiplier[2] ? 4'(4'h8 - {1'b0, group_multiplier}) : 4'h0;
    sew_scaled = 12'({4'h0, selected_element_width} << shift);
    bad = req_raw[XLEN-1]
        | (|req_raw[XLEN-2:`VCS_VT_RSVD_LSB])
        | (selected_element_width == 8'h00)
        | (12'(selected_element_width) > 12'(MAX_ELEMENT_BITS))
        | (group_multiplier == `VCS_GROUP_MULTIPLIER_RESERVED);
    // fractional groups must still hold a whole element
    if (RESTRICT_FRAC && group_multiplier[2] && (sew_scaled > 12'(MAX_ELEMENT_BITS))) begin
      bad = 1'b1;
    end
    result = '0;
    if (bad) begin
      result.config_illegal = 1'b1;
    end else begin
      result.mask_agnostic = req_raw[`VCS_VT_MASK_AGN];
      result.tail_agnostic = req_raw[`VCS_VT_TAIL_AGN];
      result.element_width_sel = req_raw[`VCS_VT_SEW_MSB:`VCS_VT_SEW_LSB];
      result.group_mult_sel = group_multiplier;
    end
  end

endmodule : vcs_vtype_check
`default_nettype wire

/* testbench/vcs_pipe_model.sv */
`timescale 1ns/100ps
`default_nettype none
module vcs_pipe_model #(
  parameter int XLEN = 32,
  parameter int VECTOR_REG_BITS = 128
) (
  input wire logic clk,
  output var vcs_pkg::vcs_op_t op,
  output logic setvl_valid,
  output logic [XLEN-1:0] setvl_vtype,
  output logic vreg_we,
  output logic [4:0] vreg_waddr,
  output logic [VECTOR_REG_BITS-1:0] vreg_wdata
);
  import vcs_pkg::*;
  initial begin
    op = '0;
    setvl_valid = 1'b0;
    setvl_vtype = '0;
    vreg_we = 1'b0;
    vreg_waddr = 5'h00;
    vreg_wdata = '0;
  end
  // one request per edge; released data lines toggle so no stale value looks valid
  task automatic put(input vcs_op_t o, input logic sv, input logic [XLEN-1:0] vt,
                     input logic we, input logic [4:0] wa, input logic [VECTOR_REG_BITS-1:0] wd);
    @(posedge clk);
    op <= o;
    setvl_valid <= sv;
    setvl_vtype <= sv ? vt : ~setvl_vtype;
    vreg_we <= we;
    vreg_waddr <= wa;
    vreg_wdata <= we ? wd : ~vreg_wdata;
  endtask : put
  task automatic idle();
    put('0, 1'b0, '0, 1'b0, 5'h00, '0);
  endtask : idle
endmodule : vcs_pipe_model
`default_nettype wire

/* testbench/vcs_vector_state_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module vcs_vector_state_monitor #(
  parameter int XLEN = 32,
  parameter int VECTOR_REG_BITS = 128
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire vcs_pkg::vcs_op_t op,
  input wire logic virt_mode,
  input wire logic ms_vs_wr,
  input wire logic gs_vs_wr,
  input wire logic ms_sd_base,
  input wire logic gs_sd_base,
  input wire logic setvl_valid,
  input wire logic [XLEN-1:0] setvl_vtype,
  input wire vcs_pkg::vcs_status_t status,
  input wire logic illegal_instr,
  input wire logic [XLEN-1:0] vtype_rdata,
  input wire vcs_pkg::vcs_vtype_t vtype_fields,
  input wire logic [16:0] elements_per_reg
);
  import vcs_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // accepted state change with no software write racing it
  wire logic mod_ok = op.valid && op.modifies && !illegal_instr && !ms_vs_wr && !gs_vs_wr;
  trap_off_a: assert property (op.valid && status.mstatus_vs == ctx_off |-> illegal_instr)
    else $error("vector op not trapped with context off");
  virt_trap_a: assert property (op.valid && virt_mode && status.vsstatus_vs == ctx_off |-> illegal_instr)
    else $error("guest off did not trap");
  dirty_set_a: assert property (mod_ok && status.mstatus_vs inside {ctx_initial, ctx_clean}
    |=> status.mstatus_vs == ctx_dirty) else $error("context not dirtied");
  both_dirty_a: assert property (mod_ok && virt_mode
    |=> status.mstatus_vs == ctx_dirty && status.vsstatus_vs == ctx_dirty) else $error("both not dirty");
  msd_a: assert property (status.mstatus_sd == (status.mstatus_vs == ctx_dirty || ms_sd_base))
    else $error("machine summary bit wrong");
  gsd_a: assert property (status.vsstatus_sd == (status.vsstatus_vs == ctx_dirty || gs_sd_base))
    else $error("guest summary bit wrong");
  sview_a: assert property (status.sstatus_vs == status.mstatus_vs)
    else $error("supervisor view differs");
  type_layout_a: assert property (vtype_rdata == {vtype_fields.config_illegal,
    {(XLEN-9){1'b0}}, vtype_fields[7:0]}) else $error("type register layout wrong");
  csr_ro_a: assert property (op.valid && op.is_csr && op.csr_write && op.csr_is_vtype &&
    !setvl_valid |-> illegal_instr ##1 $stable(vtype_rdata)) else $error("type register written");
  setvl_upd_a: assert property (setvl_valid && !illegal_instr |=> vtype_rdata ==
    $past(setvl_vtype) || vtype_rdata == {1'b1, {(XLEN-1){1'b0}}}) else $error("bad type update");
  rsvd_code_a: assert property (setvl_valid && !illegal_instr &&
    (setvl_vtype[5] || setvl_vtype[2:0] == 3'h4) |=> vtype_fields.config_illegal)
    else $error("reserved code accepted");
  elems_a: assert property (elements_per_reg == (vtype_fields.config_illegal ? 17'h0 :
    17'((VECTOR_REG_BITS >> 3) >> vtype_fields.element_width_sel))) else $error("element count");
  cover property (op.valid && op.modifies && status.mstatus_vs == ctx_clean);
  cover property (setvl_valid ##1 vtype_fields.config_illegal);
  cover property (virt_mode && op.valid && illegal_instr);
endmodule : vcs_vector_state_monitor
bind vcs_vector_state vcs_vector_state_monitor #(.XLEN(XLEN), .VECTOR_REG_BITS(VECTOR_REG_BITS))
  u_mon (.clk(clk), .arst_n(arst_n), .op(op), .virt_mode(virt_mode), .ms_vs_wr(ms_vs_wr),
  .gs_vs_wr(gs_vs_wr), .ms_sd_base(ms_sd_base), .gs_sd_base(gs_sd_base),
  .setvl_valid(setvl_valid), .setvl_vtype(setvl_vtype), .status(status),
  .illegal_instr(illegal_instr), .vtype_rdata(vtype_rdata), .vtype_fields(vtype_fields),
  .elements_per_reg(elements_per_reg));
`default_nettype wire

/* testbench/vcs_vector_state_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module vcs_vector_state_tb_top;
  import vcs_pkg::*;
  localparam vcs_op_t OP_MOD = 5'h11;
  localparam vcs_op_t OP_RD = 5'h18;
  localparam vcs_op_t OP_VTW = 5'h1E;
  localparam logic [31:0] ILL = 32'h8000_0000;
  logic clk, arst_n, virt_mode, misa_v_wr, misa_v_wdata, misa_v, ms_vs_wr, gs_vs_wr;
  logic ms_sd_base, gs_sd_base, setvl_valid, vreg_we, illegal_instr;
  logic [1:0] ms_vs_wdata, gs_vs_wdata;
  logic [4:0] vreg_waddr, vreg_raddr;
  logic [31:0] setvl_vtype, vtype_rdata;
  logic [127:0] vreg_wdata, vreg_rdata;
  logic [16:0] elements_per_reg;
  vcs_op_t op;
  vcs_status_t status;
  vcs_vtype_t vtype_fields;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  vcs_vector_state DUT (.clk(clk), .arst_n(arst_n), .op(op), .virt_mode(virt_mode),
    .misa_v_wr(misa_v_wr), .misa_v_wdata(misa_v_wdata), .misa_v(misa_v), .ms_vs_wr(ms_vs_wr),
    .ms_vs_wdata(ms_vs_wdata), .gs_vs_wr(gs_vs_wr), .gs_vs_wdata(gs_vs_wdata),
    .ms_sd_base(ms_sd_base), .gs_sd_base(gs_sd_base), .setvl_valid(setvl_valid),
    .setvl_vtype(setvl_vtype), .vreg_we(vreg_we), .vreg_waddr(vreg_waddr),
    .vreg_wdata(vreg_wdata), .vreg_raddr(vreg_raddr), .vreg_rdata(vreg_rdata), .status(status),
    .illegal_instr(illegal_instr), .vtype_rdata(vtype_rdata), .vtype_fields(vtype_fields),
    .elements_per_reg(elements_per_reg));
  vcs_pipe_model pm (.clk(clk), .op(op), .setvl_valid(setvl_valid), .setvl_vtype(setvl_vtype),
    .vreg_we(vreg_we), .vreg_waddr(vreg_waddr), .vreg_wdata(vreg_wdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic sw(input logic mw, input logic [1:0] mv, input logic gw, input logic [1:0] gv);
    @(posedge clk);
    ms_vs_wr <= mw;
    ms_vs_wdata <= mv;
    gs_vs_wr <= gw;
    gs_vs_wdata <= gv;
    @(posedge clk);
    ms_vs_wr <= 1'b0;
    gs_vs_wr <= 1'b0;
    #10;
  endtask : sw
  task automatic misa(input logic v);
    @(posedge clk);
    misa_v_wr <= 1'b1;
    misa_v_wdata <= v;
    @(posedge clk);
    misa_v_wr <= 1'b0;
    #10;
  endtask : misa
  // one op or set-length request, trap flag judged while it stands
  task automatic go(input vcs_op_t o, input logic sv, input logic [31:0] w, input logic ill);
    pm.put(o, sv, w, 1'b0, 5'h00, '0);
    #10;
    `CHK("illegal_instr", ill, illegal_instr)
    pm.idle();
    #10;
  endtask : go
  task automatic t_reset();
    #10;
    `CHK("ms_vs", ctx_off, status.mstatus_vs)
    `CHK("misa_v", 1'b1, misa_v)
    `CHK("vtype", ILL, vtype_rdata)
    `CHK("elements", 17'h0, elements_per_reg)
    go(OP_MOD, 1'b0, 32'h0, 1'b1);
    go(OP_RD, 1'b0, 32'h0, 1'b1);
    go('0, 1'b1, 32'h0, 1'b1);
    `CHK("vtype", ILL, vtype_rdata)
    `CHK("ms_vs", ctx_off, status.mstatus_vs)
    $display("reset and off test done");
  endtask : t_reset
  task automatic t_dirty();
    sw(1'b1, 2'h2, 1'b0, 2'h0);
    `CHK("ms_vs", ctx_clean, status.mstatus_vs)
    `CHK("ss_vs", ctx_clean, status.sstatus_vs)
    `CHK("ms_sd", 1'b0, status.mstatus_sd)
    go(OP_MOD, 1'b0, 32'h0, 1'b0);
    `CHK("ms_vs", ctx_dirty, status.mstatus_vs)
    `CHK("ms_sd", 1'b1, status.mstatus_sd)
    sw(1'b1, 2'h1, 1'b0, 2'h0);
    go('0, 1'b1, 32'h8, 1'b0);
    `CHK("ms_vs", ctx_dirty, status.mstatus_vs)
    $display("dirty test done");
  endtask : t_dirty
  task automatic t_setvl();
    // legal words keep the reserved span clear; index 7 breaks that on purpose
    logic [31:0] w [12] = '{32'h0, 32'h20, 32'h8, 32'h38, 32'h10, 32'h4, 32'hD8, 32'h100,
                            32'h5, ILL, 32'hD, 32'h17};
    logic [11:0] ok = 12'h955;
    for (int i = 0; i < 12; i++) begin
      go('0, 1'b1, w[i], 1'b0);
      `CHK("vtype", (ok[i] ? w[i] : ILL), vtype_rdata)
      `CHK("sew", (ok[i] ? w[i][5:3] : 3'h0), vtype_fields.element_width_sel)
      `CHK("elements", (ok[i] ? 17'(17'h10 >> w[i][5:3]) : 17'h0), elements_per_reg)
    end
    go(OP_VTW, 1'b0, 32'h0, 1'b1);
    `CHK("vtype", 32'h17, vtype_rdata)
    $display("type test done");
  endtask : t_setvl
  task automatic t_virt();
    @(posedge clk);
    virt_mode <= 1'b1;
    sw(1'b1, 2'h3, 1'b1, 2'h0);
    go(OP_MOD, 1'b0, 32'h0, 1'b1);
    sw(1'b1, 2'h2, 1'b1, 2'h1);
    `CHK("vs_vs", ctx_initial, status.vsstatus_vs)
    `CHK("vs_sd", 1'b0, status.vsstatus_sd)
    go(OP_MOD, 1'b0, 32'h0, 1'b0);
    `CHK("ms_vs", ctx_dirty, status.mstatus_vs)
    `CHK("vs_vs", ctx_dirty, status.vsstatus_vs)
    `CHK("vs_sd", 1'b1, status.vsstatus_sd)
    sw(1'b0, 2'h0, 1'b1, 2'h2);
    @(posedge clk);
    gs_sd_base <= 1'b1;
    #10;
    `CHK("vs_sd", 1'b1, status.vsstatus_sd)
    @(posedge clk);
    virt_mode <= 1'b0;
    gs_sd_base <= 1'b0;
    $display("guest test done");
  endtask : t_virt
  task automatic t_vreg();
    sw(1'b1, 2'h2, 1'b0, 2'h0);
    pm.put('0, 1'b0, '0, 1'b1, 5'h00, {4{32'hA5A5_0F0F}});
    pm.put('0, 1'b0, '0, 1'b1, 5'h1F, {4{32'h5A5A_F0F0}});
    pm.idle();
    @(posedge clk);
    vreg_raddr <= 5'h00;
    @(posedge clk);
    vreg_raddr <= 5'h1F;
    #10;
    `CHK("vreg0", {4{32'hA5A5_0F0F}}, vreg_rdata)
    @(posedge clk);
    #10;
    `CHK("vreg31", {4{32'h5A5A_F0F0}}, vreg_rdata)
    `CHK("ms_vs", ctx_dirty, status.mstatus_vs)
    misa(1'b0);
    `CHK("misa_v", 1'b0, misa_v)
    go(OP_MOD, 1'b0, 32'h0, 1'b1);
    sw(1'b1, 2'h2, 1'b0, 2'h0);
    `CHK("ms_vs", ctx_clean, status.mstatus_vs)
    misa(1'b1);
    $display("register file and enable test done");
  endtask : t_vreg
  initial begin
    arst_n = 1'b0;
    virt_mode = 1'b0;
    misa_v_wr = 1'b0;
    misa_v_wdata = 1'b0;
    ms_vs_wr = 1'b0;
    ms_vs_wdata = 2'h0;
    gs_vs_wr = 1'b0;
    gs_vs_wdata = 2'h0;
    ms_sd_base = 1'b0;
    gs_sd_base = 1'b0;
    vreg_raddr = 5'h00;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_dirty();
    t_setvl();
    t_virt();
    t_vreg();
    wrap_up();
  end
endmodule : vcs_vector_state_tb_top
`default_nettype wire
